// File: design/sar_adc_regs.svh
// Purpose: timing and layout constants for the serial readout block
// Assumes: clk at 250 MHz (4 ns)
// Notes: times kept in their own units, cycle counts derived
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH
`define SAR_CLK_PS 4000
`define SAR_CONV_MAX_NS 2200
`define SAR_CONV_CYC ((`SAR_CONV_MAX_NS * 1000) / `SAR_CLK_PS)
`define SAR_BCLK_NS 110
`define SAR_BCLK_HALF_CYC (((`SAR_BCLK_NS * 1000) / `SAR_CLK_PS) / 2)
`define SAR_START_DLY_NS 270
`define SAR_START_DLY_CYC ((`SAR_START_DLY_NS * 1000) / `SAR_CLK_PS)
`define SAR_FRAME_BITS 16
`define SAR_RESULT_BITS 12
`define SAR_PAD_BITS 4
`define SAR_PINS_IDLE 6'h30
`endif

// File: design/sar_pkg.sv
// Purpose: types for the serial readout block
// Assumes: nothing
// Notes: state enum and pin carrier struct
package sar_pkg;
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_WAIT = 2'b01,
    SAR_SHIFT = 2'b10
  } sar_int_state_t;
  typedef struct packed {
    logic cs_n;
    logic rc;
    logic ext_clk_mode;
    logic output_format_select;
    logic tag;
    logic bclk_in;
  } sar_pins_t;
endpackage

// File: design/sar_adc_serial_readout.sv
// Purpose: conversion control and serial result readout of a 12-bit SAR converter
// Assumes: all pins asynchronous to clk; result word comes from the analog core
// Notes: 16-bit frame, result msb first, then four padding zeros
// Overview of operation
// - busy goes low at conversion start, high in the same cycle the result register is loaded
// - chip select and read/convert are ORed into one effective strobe
// - serial data follows the bit clock, coded per the format select
// - external clock: after 16 bits output chain input while strobe conditions hold
// - internal clock: each data bit stable across both bit clock edges
// - internal clock: idle output holds chain level captured at conversion start
// - conversion finishes and busy releases within 2.2 us
// - generated bit clock period is 104 ns, two 13-cycle halves from the 110 ns setting
// - internal bit clock starts 67 cycles (268 ns) after strobe falls, from the 270 ns setting
// - internal mode emits exactly 16 pulses, then holds clock low
// - with chip select low, read/convert fall starts a conversion
// - format select high gives straight binary, low gives two's complement
// - clock source select high shifts on host clock, else device drives it
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module sar_adc_serial_readout
  import sar_pkg::*;
#(
  parameter int CONV_CYC = `SAR_CONV_CYC,
  parameter int BCLK_HALF_CYC = `SAR_BCLK_HALF_CYC,
  parameter int START_DLY_CYC = `SAR_START_DLY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // device pins
  input wire sar_pins_t pins,
  // analog core result, straight binary
  input wire logic [`SAR_RESULT_BITS-1:0] core_result,
  // outputs
  output logic busy_n,
  output logic serial_data,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe
);
  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  sar_pins_t s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // pins rest at their idle levels so no false strobe edge follows reset
      s1_reg <= sar_pins_t'(`SAR_PINS_IDLE);
      s2_reg <= sar_pins_t'(`SAR_PINS_IDLE);
      s3_reg <= sar_pins_t'(`SAR_PINS_IDLE);
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic strobe, strobe_d, start_ev, ext_rise;
  assign strobe = s2_reg.cs_n | s2_reg.rc;
  assign strobe_d = s3_reg.cs_n | s3_reg.rc;
  assign start_ev = strobe_d & ~strobe & ~s2_reg.cs_n;
  assign ext_rise = s2_reg.bclk_in & ~s3_reg.bclk_in;
  ////////////////////////////////////////////////////////////////////////
  // conversion timer and result coding
  logic conv_reg, conv_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [`SAR_FRAME_BITS-1:0] res_reg, res_next;
  logic tagcap_reg, tagcap_next;
  function automatic logic [`SAR_FRAME_BITS-1:0] frame_of(
    input logic [`SAR_RESULT_BITS-1:0] r, input logic sb);
    logic [`SAR_RESULT_BITS-1:0] c;
    c = sb ? r : {~r[`SAR_RESULT_BITS-1], r[`SAR_RESULT_BITS-2:0]};
    frame_of = {c, {`SAR_PAD_BITS{1'b0}}};
  endfunction
  logic done;
  assign done = conv_reg && (cnt_reg == 16'(CONV_CYC - 1));
  always_comb begin
    conv_next = conv_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    tagcap_next = tagcap_reg;
    if (start_ev && !conv_reg) begin
      conv_next = 1'b1;
      cnt_next = '0;
      tagcap_next = s2_reg.tag;
    end else if (done) begin
      conv_next = 1'b0;
      res_next = frame_of(core_result, s2_reg.output_format_select);
    end else if (conv_reg) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      res_reg <= 16'h0000;
      tagcap_reg <= 1'b0;
    end else begin
      conv_reg <= conv_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      tagcap_reg <= tagcap_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // serial shifter, internal or external bit clock
  sar_int_state_t st_reg, st_next;
  logic [`SAR_FRAME_BITS-1:0] sh_reg, sh_next;
  logic [4:0] bits_reg, bits_next;
  logic [15:0] tm_reg, tm_next;
  logic bclk_reg, bclk_next, dout_reg, dout_next, busy_reg, busy_next;
  logic ext_load, ext_active;
  // read window opens on rc rise with cs low or on cs fall with rc high
  assign ext_load = s2_reg.ext_clk_mode && ext_active && (s3_reg.cs_n || !s3_reg.rc);
  assign ext_active = !s2_reg.cs_n && s2_reg.rc;
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    bits_next = bits_reg;
    tm_next = tm_reg;
    bclk_next = 1'b0;
    dout_next = dout_reg;
    busy_next = ~(conv_next);
    if (s2_reg.ext_clk_mode) begin
      st_next = SAR_IDLE;
      if (ext_load) begin
        sh_next = res_reg;
        bits_next = '0;
        dout_next = res_reg[`SAR_FRAME_BITS-1];
      end else if (ext_rise && ext_active) begin
        if (bits_reg < 5'(`SAR_FRAME_BITS - 1)) begin
          sh_next = {sh_reg[`SAR_FRAME_BITS-2:0], 1'b0};
          dout_next = sh_reg[`SAR_FRAME_BITS-2];
          bits_next = bits_reg + 5'h01;
        end else begin
          bits_next = 5'(`SAR_FRAME_BITS);
          dout_next = s2_reg.tag;
        end
      end else if (bits_reg == 5'(`SAR_FRAME_BITS) && ext_active) begin
        dout_next = s2_reg.tag;
      end
    end else begin
      unique case (st_reg)
        SAR_IDLE: begin
          dout_next = tagcap_next;
          if (start_ev) begin
            st_next = SAR_WAIT;
            sh_next = res_reg;
            tm_next = '0;
          end
        end
        SAR_WAIT: begin
          dout_next = sh_reg[`SAR_FRAME_BITS-1];
          tm_next = tm_reg + 16'h0001;
          if (tm_reg == 16'(START_DLY_CYC - 1)) begin
            st_next = SAR_SHIFT;
            tm_next = '0;
            bits_next = '0;
          end
        end
        SAR_SHIFT: begin
          // data changes only mid-low phase, so it holds over both edges
          tm_next = tm_reg + 16'h0001;
          bclk_next = bclk_reg;
          if (tm_reg == 16'(BCLK_HALF_CYC - 1)) begin
            tm_next = '0;
            bclk_next = ~bclk_reg;
            if (bclk_reg) begin
              bits_next = bits_reg + 5'h01;
              if (bits_reg == 5'(`SAR_FRAME_BITS - 1)) begin
                st_next = SAR_IDLE;
                bclk_next = 1'b0;
              end
            end
          end
          if (!bclk_reg && tm_reg == 16'((BCLK_HALF_CYC - 1) / 2)) begin
            dout_next = sh_reg[`SAR_FRAME_BITS-1];
          end else if (bclk_reg && tm_reg == 16'(BCLK_HALF_CYC - 1)) begin
            sh_next = {sh_reg[`SAR_FRAME_BITS-2:0], tagcap_reg};
          end
          // last bit held over its falling edge, idle level follows a cycle later
          if (st_next == SAR_IDLE) begin
            dout_next = dout_reg;
          end
        end
        default: st_next = SAR_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SAR_IDLE;
      sh_reg <= 16'h0000;
      bits_reg <= 5'h00;
      tm_reg <= 16'h0000;
      bclk_reg <= 1'b0;
      dout_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      tm_reg <= tm_next;
      bclk_reg <= bclk_next;
      dout_reg <= dout_next;
      busy_reg <= busy_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // output enable for the two-way bit clock pin
  logic oe_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= ~s2_reg.ext_clk_mode;
    end
  end
  assign busy_n = busy_reg;
  assign serial_data = dout_reg;
  assign serial_bit_clock_out = bclk_reg;
  assign serial_bit_clock_oe = oe_reg;
endmodule

// File: testbench/sar_adc_monitor.sv
// Purpose: timing checks on the readout block
// Assumes: bench half bit clock of 2 cycles
// Notes: bound to the design top
`timescale 1ns/100ps
module sar_adc_monitor
  import sar_pkg::*;
#(parameter int CONV_CYC = 550) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire sar_pins_t pins,
  input wire logic [11:0] core_result,
  // outputs
  input wire logic busy_n,
  input wire logic serial_data,
  input wire logic serial_bit_clock_out,
  input wire logic serial_bit_clock_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] lo_reg, lo_next;
  logic [4:0] pc_reg, pc_next;
  logic bq_reg, oq_reg;
  wire logic sck = serial_bit_clock_out;
  always_comb begin
    lo_next = busy_n ? 16'h0 : lo_reg + 16'h1;
    pc_next = (bq_reg && !busy_n) ? 5'h0 : pc_reg + {4'h0, sck && !oq_reg};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {lo_reg, pc_reg, bq_reg, oq_reg} <= '0;
    else {lo_reg, pc_reg, bq_reg, oq_reg} <= {lo_next, pc_next, busy_n, sck};
  end
  sequence strobe_s; $fell(pins.cs_n | pins.rc) && !pins.cs_n && busy_n; endsequence
  sequence lead_s; !sck [*3] ##[1:10] sck; endsequence
  busy_start_a: assert property (strobe_s |-> ##[1:6] !busy_n) else $error("busy late");
  busy_len_a: assert property ($rose(busy_n) |-> lo_reg == CONV_CYC) else $error("len");
  oe_mode_a: assert property ($stable(pins.ext_clk_mode) [*5] |-> serial_bit_clock_oe == !pins.ext_clk_mode) else $error("oe");
  pulse_cnt_a: assert property ($rose(sck) |-> pc_reg < 5'h10) else $error("pulses");
  high_phase_a: assert property ($rose(sck) |=> sck ##1 !sck) else $error("phase");
  data_hold_a: assert property ((sck != $past(sck)) && serial_bit_clock_oe |-> $stable(serial_data)) else $error("data");
  lead_in_a: assert property ($fell(busy_n) && serial_bit_clock_oe |-> lead_s) else $error("lead");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> busy_n && !sck) else $error("rst");
endmodule
bind sar_adc_serial_readout sar_adc_monitor #(.CONV_CYC(CONV_CYC)) sar_adc_monitor_i (
  .clk(clk), .rst(rst), .pins(pins), .core_result(core_result), .busy_n(busy_n),
  .serial_data(serial_data), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe(serial_bit_clock_oe));

// File: testbench/sar_host.sv
// Purpose: host serial port model
// Assumes: host bit clock of 160 ns
// Notes: bit clock rests low between frames
`timescale 1ns/100ps
module sar_host (
  // link
  input wire logic clk,
  input wire logic serial_data,
  input wire logic serial_bit_clock_out,
  output logic bclk
);
  logic q[$];
  initial bclk = 1'b0;
  always @(posedge serial_bit_clock_out) q.push_back(serial_data);
  task automatic ext_read(output logic [17:0] bits);
    for (int i = 17; i >= 0; i--) begin
      repeat (20) @(negedge clk);
      bits[i] = serial_data;
      bclk = 1'b1;
      repeat (20) @(negedge clk);
      bclk = 1'b0;
    end
  endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the readout block
// Assumes: shortened counts
// Notes: frame model from result, format and chain level
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  import sar_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rc = 1'b1, mode = 1'b0, fmt = 1'b1, tag = 1'b0;
  logic bclk, busy_n, sdo, sck, oe;
  logic [11:0] res = 12'h0;
  logic [17:0] bits;
  logic [15:0] exp_f, got;
  logic [31:0] seed = 32'hb97d5de0;
  int miscompares = 0, tests_run = 0, cyc = 0;
  sar_pins_t pins;
  assign pins = {cs_n, rc, mode, fmt, tag, bclk};
  always #2 clk = ~clk;
  sar_adc_serial_readout #(.CONV_CYC(20), .BCLK_HALF_CYC(2), .START_DLY_CYC(4))
    sar_adc_serial_readout_i (.clk(clk), .rst(rst), .pins(pins), .core_result(res),
    .busy_n(busy_n), .serial_data(sdo), .serial_bit_clock_out(sck), .serial_bit_clock_oe(oe));
  sar_host sar_host_i (.clk(clk), .serial_data(sdo), .serial_bit_clock_out(sck), .bclk(bclk));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 60 && busy_n !== v; k++) @(negedge clk);
    `CHK("busy_n", v, busy_n)
  endtask
  task automatic strobe(input logic via_cs);
    @(negedge clk);
    {cs_n, rc} = via_cs ? 2'b10 : 2'b01;
    repeat (4) @(negedge clk);
    {cs_n, rc} = 2'b00;
    wait_busy(1'b0);
    rc = 1'b1;
    @(negedge clk);
    rc = 1'b0;
    wait_busy(1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {mode, fmt} = i[1:0];
      seed = xs(seed);
      res = seed[11:0];
      strobe(i[2]);
      exp_f = {res[11] ^ !fmt, res[10:0], 4'h0};
      if (mode) begin
        if (i[2]) begin
          {cs_n, rc} = 2'b11;
          repeat (4) @(negedge clk);
        end
        {cs_n, rc} = 2'b01;
        sar_host_i.ext_read(bits);
        `CHK("frame", exp_f, bits[17:2])
        `CHK("chain", {2{tag}}, bits[1:0])
      end else begin
        repeat (120) @(negedge clk);
        sar_host_i.q.delete();
        tag = seed[12];
        strobe(i[2]);
        tag = !tag;
        repeat (120) @(negedge clk);
        `CHK("pulses", 32'h10, sar_host_i.q.size())
        for (int k = 0; k < 16; k++) got = {got[14:0], sar_host_i.q[k]};
        `CHK("frame", exp_f, got)
        `CHK("idle", !tag, sdo)
      end
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule
